// [dv/irc_ctx_assertions.sv]
// Concurrent checks on the ports of the receive context run/status block
// Bound into irc_ctx_run_status; single clock domain, rst asynchronous high
`timescale 1ns/1ns
`default_nettype none
module irc_ctx_checker (
    input wire logic        ref_clk,          // Clock
    input wire logic        rst,              // Reset
    input wire logic        sw_reset,         // Software reset
    input wire logic        avs_read,         // Read request
    input wire logic        avs_write,        // Write request
    input wire logic [31:0] avs_readdata,     // Read data
    input wire logic        avs_waitrequest,  // Wait
    input wire logic        desc_fetch,       // Fetch pulse
    input wire logic        engine_busy,      // Engine busy
    input wire logic        fatal_error,      // Fatal error
    input wire logic        pkt_done,         // Packet done
    input wire logic        pkt_beta,         // Packet beta
    input wire logic        pkt_len_err,      // Length error
    input wire logic        pkt_crc_err,      // CRC error
    input wire logic        pkt_overrun,      // Overrun
    input wire logic        run,              // Run
    input wire logic        wake,             // Wake
    input wire logic        dead,             // Dead
    input wire logic        active,           // Active
    input wire logic        fill_buffer_mode, // Fill mode
    input wire logic        pkt_backout,      // Backout
    input wire logic        resp_beta         // Response beta
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ****************************************
    // Checks
    // ****************************************
    run_by_sw_a: assert property ($changed(run) |-> $past(sw_reset)
                                  || ($past(avs_write) && !$past(avs_waitrequest)))
        else $error("run changed without a write or reset");
    sw_reset_clr_a: assert property (sw_reset |=> !run && !wake && !dead && !active)
        else $error("software reset left state set");
    wake_fetch_a: assert property (desc_fetch |=> !wake)
        else $error("wake kept over a fetch");
    dead_set_a: assert property (fatal_error |=> dead)
        else $error("dead not set on fatal error");
    dead_clr_a: assert property ($fell(dead) |-> ($past(run) && !run) || $past(sw_reset))
        else $error("dead cleared without run clear");
    active_ok_a: assert property (active |-> run && !dead)
        else $error("active without run or while dead");
    active_on_a: assert property (run && !dead && engine_busy && !avs_write && !sw_reset && !fatal_error |=> active)
        else $error("active not set while processing");
    backout_pulse_a: assert property (pkt_backout == ($past(pkt_done) && $past(fill_buffer_mode)
                                      && ($past(pkt_len_err) || $past(pkt_crc_err) || $past(pkt_overrun))))
        else $error("backout pulse wrong");
    resp_beta_a: assert property (pkt_done |=> resp_beta == $past(pkt_beta))
        else $error("response format does not follow packet");
    reserved_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[14:13] == 2'h0 && !avs_readdata[8])
        else $error("reserved bits read nonzero");
    read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer timing wrong");

    cover property (fatal_error ##1 dead);
    cover property (pkt_backout);
    cover property (desc_fetch ##1 !wake);
    cover property ($rose(active));
endmodule
bind irc_ctx_run_status irc_ctx_checker u_chk (.ref_clk(ref_clk), .rst(rst), .sw_reset(sw_reset),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .desc_fetch(desc_fetch), .engine_busy(engine_busy), .fatal_error(fatal_error), .pkt_done(pkt_done),
    .pkt_beta(pkt_beta), .pkt_len_err(pkt_len_err), .pkt_crc_err(pkt_crc_err), .pkt_overrun(pkt_overrun),
    .run(run), .wake(wake), .dead(dead), .active(active), .fill_buffer_mode(fill_buffer_mode),
    .pkt_backout(pkt_backout), .resp_beta(resp_beta));
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the receive context run/status block
// Drives the Avalon-MM slave and the engine and packet inputs directly
`timescale 1ns/1ns
`default_nettype none
`include "irc_ctx_map.vh"
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        sw_reset = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        desc_fetch = 1'b0;
    logic        engine_busy = 1'b0;
    logic        fatal_error = 1'b0;
    logic        pkt_done = 1'b0;
    logic [2:0]  pkt_speed = 3'h0;
    logic        pkt_beta = 1'b0;
    logic [4:0]  pkt_event = 5'h00;
    logic        pkt_len_err = 1'b0;
    logic        pkt_crc_err = 1'b0;
    logic        pkt_overrun = 1'b0;
    logic        run, wake, dead, active, fill_buffer_mode, keep_header;
    logic        cycle_match_enable, multi_channel, dual_buffer, pkt_backout, resp_beta, irq;
    int          fails = 0;
    int          n_compared = 0;
    logic [31:0] q;
    logic [4:0]  evts [8] = '{`IRC_EVT_COMPLETE, `IRC_EVT_DATA_ERR, `IRC_EVT_LONG_PKT, `IRC_EVT_OVERRUN,
                              `IRC_EVT_DESC_RD, `IRC_EVT_DATA_WR, `IRC_EVT_UNKNOWN, 5'h0a};

    always #5 ref_clk = ~ref_clk;

    irc_ctx_run_status u_dut (.ref_clk(ref_clk), .rst(rst), .sw_reset(sw_reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .desc_fetch(desc_fetch),
        .engine_busy(engine_busy), .fatal_error(fatal_error), .pkt_done(pkt_done), .pkt_speed(pkt_speed),
        .pkt_beta(pkt_beta), .pkt_event(pkt_event), .pkt_len_err(pkt_len_err), .pkt_crc_err(pkt_crc_err),
        .pkt_overrun(pkt_overrun), .run(run), .wake(wake), .dead(dead), .active(active),
        .fill_buffer_mode(fill_buffer_mode), .keep_header(keep_header), .cycle_match_enable(cycle_match_enable),
        .multi_channel(multi_channel), .dual_buffer(dual_buffer), .pkt_backout(pkt_backout),
        .resp_beta(resp_beta), .irq(irq));

    // ****************************************
    // Bus, pulse and compare tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do
            @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(q, exp);
    endtask

    // One-cycle pulse: 0 fetch, 1 fatal error, 2 software reset
    task automatic pulse(input int sel);
        @(posedge ref_clk);
        desc_fetch <= (sel == 0);
        fatal_error <= (sel == 1);
        sw_reset <= (sel == 2);
        @(posedge ref_clk);
        desc_fetch <= 1'b0;
        fatal_error <= 1'b0;
        sw_reset <= 1'b0;
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge ref_clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    function automatic logic [4:0] fexp(input logic fill, input logic [4:0] e);
        if (e == `IRC_EVT_COMPLETE || e == `IRC_EVT_DESC_RD || e == `IRC_EVT_DATA_WR)
            return e;
        if (!fill && (e == `IRC_EVT_DATA_ERR || e == `IRC_EVT_LONG_PKT || e == `IRC_EVT_OVERRUN))
            return e;
        return `IRC_EVT_UNKNOWN;
    endfunction

    task automatic pkt(input logic fill, input int i);
        logic [2:0] er;
        er = (i < 3) ? (3'b001 << i) : 3'b000;
        @(posedge ref_clk);
        pkt_done <= 1'b1;
        pkt_speed <= {1'b0, i[1:0]};
        pkt_beta <= i[0];
        pkt_event <= evts[i];
        {pkt_len_err, pkt_crc_err, pkt_overrun} <= er;
        @(posedge ref_clk);
        pkt_done <= 1'b0;
        @(negedge ref_clk);
        check({30'h0, pkt_backout, resp_beta}, {30'h0, fill && er != 3'b000, i[0]});
        rd_chk(`IRC_OFS_SET, {fill, 21'h0, i[0], 2'h0, i[1:0], fexp(fill, evts[i])});
    endtask

    task automatic summarize;
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        summarize;
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(`IRC_OFS_SET, 32'h0);
        bus(1'b1, `IRC_OFS_SET, 32'h0000_8000, 4'h1);
        rd_chk(`IRC_OFS_CLR, 32'h0);
        wr(`IRC_OFS_SET, 32'h0000_ff00);
        rd_chk(`IRC_OFS_SET, 32'h0000_9000);
        pulse(0);
        rd_chk(`IRC_OFS_SET, 32'h0000_8000);
        engine_busy <= 1'b1;
        rd_chk(`IRC_OFS_SET, 32'h0000_8400);
        pulse(1);
        rd_chk(`IRC_OFS_SET, 32'h0000_8800);
        chk_irq(1'b0);
        wr(`IRC_OFS_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(`IRC_OFS_IRQ_STAT, 32'h1);
        chk_irq(1'b0);
        wr(`IRC_OFS_SET, 32'h0000_8000);
        rd_chk(`IRC_OFS_SET, 32'h0000_8800);
        wr(`IRC_OFS_CLR, 32'h0000_8000);
        rd_chk(`IRC_OFS_SET, 32'h0);
        wr(`IRC_OFS_SET, 32'h0000_9000);
        rd_chk(`IRC_OFS_SET, 32'h0000_9400);
        pulse(2);
        rd_chk(`IRC_OFS_SET, 32'h0);
        wr(12'h123, 32'hffff_ffff);
        rd_chk(12'h123, 32'h0);
        rd_chk(`IRC_OFS_SET, 32'h0);
        // Mode bits written only while stopped; dual clears fill and multi, active clears cycle match
        wr(`IRC_OFS_SET, 32'hf000_0000);
        rd_chk(`IRC_OFS_SET, 32'hf000_0000);
        check({27'h0, fill_buffer_mode, keep_header, cycle_match_enable, multi_channel, dual_buffer}, 32'h1e);
        wr(`IRC_OFS_SET, 32'h0800_0000);
        rd_chk(`IRC_OFS_CLR, 32'h6800_0000);
        wr(`IRC_OFS_SET, 32'h0000_8000);
        rd_chk(`IRC_OFS_SET, 32'h4800_8400);
        check({27'h0, fill_buffer_mode, keep_header, cycle_match_enable, multi_channel, dual_buffer}, 32'h09);
        check({28'h0, run, wake, dead, active}, 32'h9);
        wr(`IRC_OFS_CLR, 32'h0000_8000);
        wr(`IRC_OFS_CLR, 32'h4800_0000);
        rd_chk(`IRC_OFS_SET, 32'h0);
        engine_busy <= 1'b0;
        for (int i = 0; i < 8; i++)
            pkt(1'b0, i);
        rd_chk(`IRC_OFS_IRQ_STAT, 32'h2);
        wr(`IRC_OFS_SET, 32'h8000_0000);
        for (int i = 0; i < 8; i++)
            pkt(1'b1, i);
        rd_chk(`IRC_OFS_IRQ_STAT, 32'h6);
        rd_chk(`IRC_OFS_IRQ_MASK, 32'h1);
        wr(`IRC_OFS_IRQ_MASK, 32'h4);
        chk_irq(1'b1);
        wr(`IRC_OFS_IRQ_STAT, 32'h6);
        chk_irq(1'b0);
        summarize;
    end
endmodule
`default_nettype wire

// [hw/irc_ctx_map.vh]
// Register map, field positions and codes for the receive context run/status block
// Included by irc_ctx_run_status.v; definitions only
`ifndef IRC_CTX_MAP_VH
`define IRC_CTX_MAP_VH

// Byte addresses on the register bus
`define IRC_ADDR_W        12
`define IRC_OFS_SET       12'h400
`define IRC_OFS_CLR       12'h404
`define IRC_OFS_IRQ_STAT  12'h500
`define IRC_OFS_IRQ_MASK  12'h504

// Control register field positions
`define IRC_B_FILL        31
`define IRC_B_HDR         30
`define IRC_B_CYC_MATCH   29
`define IRC_B_MULTI       28
`define IRC_B_DUAL        27
`define IRC_B_RUN         15
`define IRC_B_WAKE        12
`define IRC_B_DEAD        11
`define IRC_B_ACTIVE      10
`define IRC_B_BETA        9
`define IRC_SPD_HI        7
`define IRC_SPD_LO        5
`define IRC_EVT_HI        4
`define IRC_EVT_LO        0

// Reset values
`define IRC_SPD_RST       3'h0
`define IRC_EVT_RST       5'h00
`define IRC_ZERO32        32'h0000_0000

// Event codes reported in the low field
`define IRC_EVT_COMPLETE  5'h11
`define IRC_EVT_DATA_ERR  5'h1d
`define IRC_EVT_LONG_PKT  5'h02
`define IRC_EVT_OVERRUN   5'h05
`define IRC_EVT_DESC_RD   5'h06
`define IRC_EVT_DATA_WR   5'h07
`define IRC_EVT_UNKNOWN   5'h0e

// Interrupt status bits
`define IRC_IRQ_W         3
`define IRC_IRQ_DEAD      0
`define IRC_IRQ_DONE      1
`define IRC_IRQ_BACKOUT   2

`endif

// [hw/irc_ctx_run_status.v]
// Run control and status of one isochronous receive DMA context, with an Avalon-MM slave
// Assumes the descriptor engine and receive path run on ref_clk and drive pulses for one cycle
//
// Function
// - Hardware never changes run except clearing it on hardware or software reset.
// - Bits 14 and 13 always read as zero.
// - Wake is cleared on every descriptor fetch.
// - A fatal context error sets the dead flag.
// - Dead clears only when software clears run; a software reset also clears it here.
// - Active stays high while descriptors are being processed.
// - Beta flag records whether the received packet came in beta format.
// - Responses to beta-format requests are sent in beta format.
// - Bit 8 always reads as zero.
// - Speed field: 000=100, 001=200, 010=400, 011=800 Mbit/s.
// - Buffer-fill mode reports only complete, descriptor read, data write, unknown.
// - Buffer-fill mode backs out packets with length, CRC or overrun errors.
// - Buffer-fill bit selects packing back to back versus one packet per buffer.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "irc_ctx_map.vh"

module irc_ctx_run_status (
    input  wire        ref_clk,             // System clock, 100 MHz
    input  wire        rst,                 // Asynchronous reset, active high
    input  wire        sw_reset,            // Software reset of the controller, one cycle
    input  wire [11:0] avs_address,         // Byte address
    input  wire        avs_read,            // Read request
    input  wire        avs_write,           // Write request
    input  wire [31:0] avs_writedata,       // Write data
    input  wire [3:0]  avs_byteenable,      // Byte lanes of a write
    output reg  [31:0] avs_readdata,        // Read data
    output wire        avs_waitrequest,     // Request not yet answered
    input  wire        desc_fetch,          // Engine fetched a descriptor
    input  wire        engine_busy,         // Engine has descriptors to process
    input  wire        fatal_error,         // Fatal error in the context
    input  wire        pkt_done,            // Packet finished, status below valid
    input  wire [2:0]  pkt_speed,           // Speed code of the packet
    input  wire        pkt_beta,            // Packet arrived in beta format
    input  wire [4:0]  pkt_event,           // Raw event code of the packet
    input  wire        pkt_len_err,         // Data length mismatch
    input  wire        pkt_crc_err,         // Data CRC error
    input  wire        pkt_overrun,         // Receive FIFO overrun
    output reg         run,                 // Descriptor processing enabled
    output reg         wake,                // Resume request to the engine
    output reg         dead,                // Context stopped on a fatal error
    output reg         active,              // Context is processing descriptors
    output reg         fill_buffer_mode,    // Pack packets back to back
    output reg         keep_header,         // Keep isochronous header in buffers
    output reg         cycle_match_enable,  // Start on cycle match
    output reg         multi_channel,       // Receive all masked channels
    output reg         dual_buffer,         // Split payload into two buffer series
    output reg         pkt_backout,         // Discard the packet just received
    output reg         resp_beta,           // Send the response in beta format
    output wire        irq                  // Level interrupt
);

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    reg         bus_ack;
    wire        bus_req;
    wire        wr_go;
    wire [31:0] be_mask;
    wire [31:0] wdata;
    wire        hit_set;
    wire        hit_clr;
    wire        hit_stat;
    wire        hit_mask;

    assign bus_req = avs_read | avs_write;
    // One wait cycle on every access; read data is registered during it
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_go = avs_write & bus_ack;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // Masked lanes write zeros, so set, clear and W1C leave those bits alone
    assign wdata = avs_writedata & be_mask;
    assign hit_set = (avs_address == `IRC_OFS_SET);
    assign hit_clr = (avs_address == `IRC_OFS_CLR);
    assign hit_stat = (avs_address == `IRC_OFS_IRQ_STAT);
    assign hit_mask = (avs_address == `IRC_OFS_IRQ_MASK);

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bus_ack <= 1'b0;
        else
            bus_ack <= bus_req & ~bus_ack;
    end

    // ****************************************************************
    // Software set and clear strobes
    // ****************************************************************
    wire [31:0] set_bits;
    wire [31:0] clr_bits;
    wire        stop_run;

    assign set_bits = (wr_go & hit_set) ? wdata : `IRC_ZERO32;
    assign clr_bits = (wr_go & hit_clr) ? wdata : `IRC_ZERO32;
    // Only a real running-to-stopped step counts, not a clear of a stopped context
    assign stop_run = clr_bits[`IRC_B_RUN] & run;

    // ****************************************************************
    // Next active state
    // ****************************************************************
    reg next_active;

    // Forced low in a stopping cycle so that active never outlives run
    always @*
    begin
        next_active = run & ~dead & engine_busy;
        if (stop_run | fatal_error | sw_reset)
            next_active = 1'b0;
    end

    // ****************************************************************
    // Mode bits
    // ****************************************************************
    // Software keeps these still while run or active is set
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fill_buffer_mode   <= 1'b0;
            keep_header        <= 1'b0;
            cycle_match_enable <= 1'b0;
            multi_channel      <= 1'b0;
            dual_buffer        <= 1'b0;
        end
        else
        begin
            if (set_bits[`IRC_B_DUAL])
                dual_buffer <= 1'b1;
            else if (clr_bits[`IRC_B_DUAL])
                dual_buffer <= 1'b0;
            // Setting dual-buffer clears fill and multichannel, even when set in the same write
            if (set_bits[`IRC_B_DUAL] | clr_bits[`IRC_B_FILL])
                fill_buffer_mode <= 1'b0;
            else if (set_bits[`IRC_B_FILL])
                fill_buffer_mode <= 1'b1;
            if (set_bits[`IRC_B_DUAL] | clr_bits[`IRC_B_MULTI])
                multi_channel <= 1'b0;
            else if (set_bits[`IRC_B_MULTI])
                multi_channel <= 1'b1;
            if (set_bits[`IRC_B_HDR])
                keep_header <= 1'b1;
            else if (clr_bits[`IRC_B_HDR])
                keep_header <= 1'b0;
            // Hardware drops cycle match in the cycle the context turns active
            if (next_active & ~active)
                cycle_match_enable <= 1'b0;
            else if (set_bits[`IRC_B_CYC_MATCH])
                cycle_match_enable <= 1'b1;
            else if (clr_bits[`IRC_B_CYC_MATCH])
                cycle_match_enable <= 1'b0;
        end
    end

    // ****************************************************************
    // Run, wake, dead, active
    // ****************************************************************
    // Software reset clears run, wake, dead and active only; mode bits and packet status survive it
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            run    <= 1'b0;
            wake   <= 1'b0;
            dead   <= 1'b0;
            active <= 1'b0;
        end
        else if (sw_reset)
        begin
            run    <= 1'b0;
            wake   <= 1'b0;
            dead   <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            if (set_bits[`IRC_B_RUN])
                run <= 1'b1;
            else if (clr_bits[`IRC_B_RUN])
                run <= 1'b0;
            // Fetch clears wake even if software sets it in the same cycle
            if (desc_fetch)
                wake <= 1'b0;
            else if (set_bits[`IRC_B_WAKE])
                wake <= 1'b1;
            if (fatal_error)
                dead <= 1'b1;
            else if (stop_run)
                dead <= 1'b0;
            active <= next_active;
        end
    end

    // ****************************************************************
    // Event code filter
    // ****************************************************************
    reg  [4:0] next_event;

    // Codes outside the list of the current mode report as unknown
    always @*
    begin
        next_event = `IRC_EVT_UNKNOWN;
        if (fill_buffer_mode)
        begin
            case (pkt_event)
                `IRC_EVT_COMPLETE: next_event = pkt_event;
                `IRC_EVT_DESC_RD:  next_event = pkt_event;
                `IRC_EVT_DATA_WR:  next_event = pkt_event;
                default:           next_event = `IRC_EVT_UNKNOWN;
            endcase
        end
        else
        begin
            case (pkt_event)
                `IRC_EVT_COMPLETE: next_event = pkt_event;
                `IRC_EVT_DATA_ERR: next_event = pkt_event;
                `IRC_EVT_LONG_PKT: next_event = pkt_event;
                `IRC_EVT_OVERRUN:  next_event = pkt_event;
                `IRC_EVT_DESC_RD:  next_event = pkt_event;
                `IRC_EVT_DATA_WR:  next_event = pkt_event;
                default:           next_event = `IRC_EVT_UNKNOWN;
            endcase
        end
    end

    // ****************************************************************
    // Packet status: speed, beta, event code, back-out
    // ****************************************************************
    reg  [2:0] speed;
    reg        beta_format_received;
    reg  [4:0] event_code;
    wire       pkt_bad;
    wire       backout_now;

    assign pkt_bad = pkt_len_err | pkt_crc_err | pkt_overrun;
    // Errored packets are backed out only in fill mode; per-buffer mode reports them
    assign backout_now = pkt_done & fill_buffer_mode & pkt_bad;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            speed                <= `IRC_SPD_RST;
            beta_format_received <= 1'b0;
            event_code           <= `IRC_EVT_RST;
            pkt_backout          <= 1'b0;
            resp_beta            <= 1'b0;
        end
        else
        begin
            pkt_backout <= backout_now;
            if (pkt_done)
            begin
                speed                <= pkt_speed;
                beta_format_received <= pkt_beta;
                resp_beta            <= pkt_beta;
                event_code           <= next_event;
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    reg  [`IRC_IRQ_W-1:0] irq_stat;
    reg  [`IRC_IRQ_W-1:0] irq_mask;
    wire [`IRC_IRQ_W-1:0] irq_evt;
    wire [`IRC_IRQ_W-1:0] irq_w1c;

    // Back-out has its own status bit so software can count discarded packets
    assign irq_evt = {backout_now, pkt_done, fatal_error};
    assign irq_w1c = (wr_go & hit_stat) ? wdata[`IRC_IRQ_W-1:0] : {`IRC_IRQ_W{1'b0}};
    assign irq = |(irq_stat & irq_mask);

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat <= {`IRC_IRQ_W{1'b0}};
            irq_mask <= {`IRC_IRQ_W{1'b0}};
        end
        else
        begin
            // A new event wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~irq_w1c) | irq_evt;
            if (wr_go & hit_mask)
                irq_mask <= wdata[`IRC_IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    reg [31:0] ctl_word;
    reg [31:0] next_rdata;

    always @*
    begin
        ctl_word = `IRC_ZERO32;
        ctl_word[`IRC_B_FILL] = fill_buffer_mode;
        ctl_word[`IRC_B_HDR] = keep_header;
        ctl_word[`IRC_B_CYC_MATCH] = cycle_match_enable;
        ctl_word[`IRC_B_MULTI] = multi_channel;
        ctl_word[`IRC_B_DUAL] = dual_buffer;
        ctl_word[`IRC_B_RUN] = run;
        ctl_word[`IRC_B_WAKE] = wake;
        ctl_word[`IRC_B_DEAD] = dead;
        ctl_word[`IRC_B_ACTIVE] = active;
        ctl_word[`IRC_B_BETA] = beta_format_received;
        ctl_word[`IRC_SPD_HI:`IRC_SPD_LO] = speed;
        ctl_word[`IRC_EVT_HI:`IRC_EVT_LO] = event_code;
    end

    always @*
    begin
        next_rdata = `IRC_ZERO32;
        if (hit_set | hit_clr)
            next_rdata = ctl_word;
        else if (hit_stat)
            next_rdata[`IRC_IRQ_W-1:0] = irq_stat;
        else if (hit_mask)
            next_rdata[`IRC_IRQ_W-1:0] = irq_mask;
    end

    // Captured in the wait cycle so the word stands while waitrequest is low
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= `IRC_ZERO32;
        else if (avs_read & ~bus_ack)
            avs_readdata <= next_rdata;
    end

endmodule
`default_nettype wire
